// [logic/step_cal_pkg.sv]
// Shared constants for the stepped-frequency radiometer sequencer.
// Assumes a single 100 MHz clock; all timing derives from the frame timing pulse, or from the fallback timer while that pulse is lost.
package step_cal_pkg;
  localparam int          CLK_HZ           = 100_000_000;
  localparam int          NUM_STEPS        = 8;
  localparam int          STEP_W           = 3;
  localparam int          LEVEL_W          = 2;
  localparam int          SUBCYCLES_PER_CAL = 16;
  localparam int          SUBCYC_W         = 4;
  // Calibration repeats every 2.91 hours, which is 16368 whole frames of 0.64 s.
  localparam int          CAL_PERIOD_MS    = 10_476_000;
  localparam int          FRAME_MS         = 640;
  localparam int          CAL_PERIOD_FRAMES = CAL_PERIOD_MS / FRAME_MS;
  localparam int          FRAME_CNT_W      = 15;
  // Fallback timer stands in for a lost frame pulse; slightly longer than a frame.
  localparam int          FALLBACK_MS      = 700;
  localparam longint      FALLBACK_CYCLES  = longint'(FALLBACK_MS) * (CLK_HZ / 1000);
  localparam int          FALLBACK_W       = 27;
  localparam logic [2:0]  STEP_RST         = 3'h0;
  localparam logic [1:0]  LEVEL_RST        = 2'h0;
  localparam logic [3:0]  SUBCYC_RST       = 4'h0;
  // Page id counter: the first subcycle of each 16-subcycle page shows frequency id.
  localparam logic [3:0]  PAGE_RST         = 4'h0;
endpackage : step_cal_pkg

// [logic/pulse_fallback.sv]
// Pulse source with fallback timer: passes the frame pulse through, or makes one when
// the frame pulse goes missing. Inputs are already synchronised and edge-detected.
`timescale 1ns/1ps
module pulse_fallback #(
  parameter longint TIMEOUT = 70_000_000,
  parameter int     W       = 27
) (
  input  wire logic i_mclk,
  input  wire logic i_rst_b,
  input  wire logic i_pulse,
  output logic      o_tick,
  output logic      o_lost
);
  logic [W-1:0] cnt_ff;

  // Count since the last tick; a timeout produces a substitute tick.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_ff <= '0;
      o_tick <= 1'b0;
      o_lost <= 1'b0;
    end else if (i_pulse) begin
      cnt_ff <= '0;
      o_tick <= 1'b1;
      o_lost <= 1'b0;
    end else if (cnt_ff == W'(TIMEOUT - 1)) begin
      cnt_ff <= '0;
      o_tick <= 1'b1;   // Stepping continues unsynchronised
      o_lost <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + W'(1);
      o_tick <= 1'b0;
    end
  end
endmodule : pulse_fallback

// [logic/step_cal_seq.sv]
// Stepped-frequency radiometer step and calibration sequencer.
// Assumes pins arrive asynchronously and are synchronised here; one 100 MHz clock.
//
// Summary of operation
// - Each frame timing pulse advances the oscillator one step.
// - Eight steps make a subcycle, then wrap to the first step.
// - First subcycle of each page presents frequency identification instead of output.
// - Subcycles repeat continuously unless stepping is disabled.
// - A calibration cycle lasts sixteen subcycles.
// - Level held for a subcycle, then lowered over three more subcycles.
// - The four-level sequence runs four times in all.
// - At calibration end the antennas are reconnected.
// - Calibration starts once per 2.91 hours; antennas connected otherwise.
// - Calibrator feeds one preamp; the other sees a dummy load.
// - The calibrated preamp alternates each calibration cycle.
// - The applied calibration level is output.
// - Antenna and level controls follow only the timing pulses.
// - Disable command enters single frequency mode; calibration still runs.
// - Single-step command advances one step, bypassing frame pulse path.
// - The first frame tick aligns the step logic at power-on.
// - A fallback timer substitutes for a lost frame pulse.
`timescale 1ns/1ps
module step_cal_seq
  import step_cal_pkg::*;
#(
  parameter int     CAL_FRAMES     = step_cal_pkg::CAL_PERIOD_FRAMES,
  parameter longint FALLBACK_TICKS = step_cal_pkg::FALLBACK_CYCLES
) (
  input  wire logic                           i_mclk,
  input  wire logic                           i_rst_b,
  input  wire logic                           i_frame_timing_pulse,
  input  wire logic                           i_disable_stepping_command,
  input  wire logic                           i_enable_stepping_command,
  input  wire logic                           i_single_step_command,
  output logic [step_cal_pkg::STEP_W-1:0]     o_freq_step,
  output logic                                o_freq_id_select,
  output logic                                o_cal_active,
  output logic                                o_antenna_connected,
  output logic                                o_cal_preamp_sel,
  output logic [step_cal_pkg::LEVEL_W-1:0]    o_cal_level,
  output logic                                o_single_freq_mode,
  output logic                                o_timing_lost
);
  import step_cal_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers and rising-edge detection on the pins.
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] prev_ff;
  logic [3:0] rise;

  // First stage feeds only the second stage.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      prev_ff  <= 4'h0;
    end else begin
      sync1_ff <= {i_single_step_command, i_enable_stepping_command,
                   i_disable_stepping_command, i_frame_timing_pulse};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  assign rise = sync2_ff & ~prev_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame tick, from the spacecraft pulse or the fallback timer.
  logic frame_tick;
  logic lost;

  pulse_fallback #(
    .TIMEOUT (FALLBACK_TICKS),
    .W       (FALLBACK_W)
  ) u_fallback (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_pulse (rise[0]),
    .o_tick  (frame_tick),
    .o_lost  (lost)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Mode latch: disable wins over enable if both arrive together, like a latching relay.
  logic single_ff;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      single_ff <= 1'b0;
    end else if (rise[1]) begin
      single_ff <= 1'b1;
    end else if (rise[2]) begin
      single_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power-on alignment: the step counter holds at the first step through the first tick,
  // so the first subcycle after power-on starts cleanly at the first step.
  logic aligned_ff;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aligned_ff <= 1'b0;
    end else if (frame_tick) begin
      aligned_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frequency step counter.
  logic [STEP_W-1:0] step_ff;
  logic              auto_adv;
  logic              man_adv;
  logic              subcyc_end;

  assign auto_adv   = frame_tick && !single_ff && aligned_ff;
  assign man_adv    = rise[3] && single_ff;
  // Subcycle boundary is timed by frames even in single mode, so calibration proceeds.
  logic [STEP_W-1:0] frame_ph_ff;
  assign subcyc_end = frame_tick && aligned_ff && (frame_ph_ff == STEP_W'(NUM_STEPS - 1));

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      step_ff <= STEP_RST;
    end else if (auto_adv || man_adv) begin
      step_ff <= step_ff + STEP_W'(1);   // Wraps seven to zero
    end
  end

  // Frame phase within a subcycle; equals the step until single mode is first entered.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      frame_ph_ff <= STEP_RST;
    end else if (frame_tick && aligned_ff) begin
      frame_ph_ff <= frame_ph_ff + STEP_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Page position: first subcycle of sixteen carries frequency identification.
  logic [3:0] page_ff;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      page_ff <= PAGE_RST;
    end else if (subcyc_end) begin
      page_ff <= page_ff + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Calibration interval, counted in frames only.
  logic [FRAME_CNT_W-1:0] interval_ff;
  logic                   due_ff;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      interval_ff <= '0;
      due_ff      <= 1'b0;
    end else if (frame_tick && aligned_ff) begin
      if (interval_ff == FRAME_CNT_W'(CAL_FRAMES - 1)) begin
        interval_ff <= '0;
        due_ff      <= 1'b1;
      end else begin
        interval_ff <= interval_ff + FRAME_CNT_W'(1);
        if (subcyc_end) begin
          due_ff <= 1'b0;      // Start consumed at the boundary below.
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Calibration state: sixteen subcycles, level stepped every subcycle.
  logic                cal_ff;
  logic [SUBCYC_W-1:0] subcyc_ff;
  logic [LEVEL_W-1:0]  level_ff;
  logic                preamp_ff;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cal_ff    <= 1'b0;
      subcyc_ff <= SUBCYC_RST;
      level_ff  <= LEVEL_RST;
      preamp_ff <= 1'b0;
    end else if (subcyc_end) begin
      if (cal_ff) begin
        subcyc_ff <= subcyc_ff + SUBCYC_W'(1);
        level_ff  <= level_ff + LEVEL_W'(1);   // Four levels, four rounds
        if (subcyc_ff == SUBCYC_W'(SUBCYCLES_PER_CAL - 1)) begin
          cal_ff <= 1'b0;
        end
      end else if (due_ff) begin
        cal_ff    <= 1'b1;
        subcyc_ff <= SUBCYC_RST;
        level_ff  <= LEVEL_RST;
        preamp_ff <= ~preamp_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_freq_step         <= STEP_RST;
      o_freq_id_select    <= 1'b0;
      o_cal_active        <= 1'b0;
      o_antenna_connected <= 1'b1;
      o_cal_preamp_sel    <= 1'b0;
      o_cal_level         <= LEVEL_RST;
      o_single_freq_mode  <= 1'b0;
      o_timing_lost       <= 1'b0;
    end else begin
      o_freq_step         <= step_ff;
      o_freq_id_select    <= aligned_ff && (page_ff == PAGE_RST);
      o_cal_active        <= cal_ff;
      o_antenna_connected <= !cal_ff;
      o_cal_preamp_sel    <= preamp_ff;
      o_cal_level         <= level_ff;
      o_single_freq_mode  <= single_ff;
      o_timing_lost       <= lost;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  a_step_advance: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    auto_adv |=> step_ff == $past(step_ff) + STEP_W'(1))
    else $error("step did not advance on frame tick");
  a_step_wrap: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (auto_adv && step_ff == 3'h7) |=> step_ff == 3'h0)
    else $error("step did not wrap to first");
  a_single_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (single_ff && !man_adv) |=> $stable(step_ff))
    else $error("step moved in single mode");
  a_single_step: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    man_adv |=> step_ff == $past(step_ff) + STEP_W'(1))
    else $error("single step did not advance");
  a_cal_start_aligned: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $rose(cal_ff) |-> frame_ph_ff == 3'h0 && level_ff == 2'h0)
    else $error("calibration started off boundary");
  a_cal_end_reconnect: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $fell(cal_ff) |-> ##2 o_antenna_connected)
    else $error("antennas not reconnected");
  a_level_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (cal_ff && !subcyc_end) |=> $stable(level_ff))
    else $error("level changed inside subcycle");
  a_preamp_toggle: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $rose(cal_ff) |-> preamp_ff != $past(preamp_ff))
    else $error("preamp did not alternate");
  a_antenna_excl: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_cal_active |-> !o_antenna_connected)
    else $error("antenna connected during calibration");
  a_fallback_tick: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $rose(lost) |-> frame_tick)
    else $error("lost timing without substitute tick");

  c_cal_start: cover property (@(posedge i_mclk) disable iff (!i_rst_b) $rose(cal_ff));
  c_cal_end: cover property (@(posedge i_mclk) disable iff (!i_rst_b) $fell(cal_ff));
  c_single_step: cover property (@(posedge i_mclk) disable iff (!i_rst_b) man_adv);
  c_timing_lost: cover property (@(posedge i_mclk) disable iff (!i_rst_b) $rose(lost));
endmodule : step_cal_seq

// [verif/sc_timing_model.sv]
// Model of the data system timing source and the ground command decoder.
// Assumes the caller runs off the sequencer clock; every pin changes on a falling edge.
`timescale 1ns/1ps
module sc_timing_model (
  input  wire logic i_mclk,
  output logic      o_frame_pin,
  output logic      o_disable_pin,
  output logic      o_enable_pin,
  output logic      o_step_pin
);
  ////////////////////////////////////////////////////////////////////////////
  // Every pin idles low; a frame or command is one high pulse.
  initial begin
    o_frame_pin   = 1'b0;
    o_disable_pin = 1'b0;
    o_enable_pin  = 1'b0;
    o_step_pin    = 1'b0;
  end

  // Raises one pin for three clocks, then holds it low for nine.
  // The long low tail stands for the lead of the pulse over the sampling instant.
  // which: 0 frame, 1 disable stepping, 2 enable stepping, 3 single step.
  task automatic pulse(input int which);
    @(negedge i_mclk);
    case (which)
      0: o_frame_pin = 1'b1;
      1: o_disable_pin = 1'b1;
      2: o_enable_pin = 1'b1;
      default: o_step_pin = 1'b1;
    endcase
    repeat (3) @(negedge i_mclk);
    o_frame_pin   = 1'b0;
    o_disable_pin = 1'b0;
    o_enable_pin  = 1'b0;
    o_step_pin    = 1'b0;
    repeat (9) @(negedge i_mclk);
  endtask : pulse
endmodule : sc_timing_model

// [verif/test_step_cal_seq.sv]
// Self-checking bench for the step and calibration sequencer.
// Assumes the partner model drives all pins; a short calibration interval is used.
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch at %0t: %s", $time, msg); end end
module test_step_cal_seq;
  import step_cal_pkg::*;
  localparam int     CAL_N = 40;
  // Short fallback timeout so a lost frame pulse can be shown within the run.
  localparam longint FB_N  = 300;
  logic                i_mclk;
  logic                i_rst_b;
  logic                frame_pin, dis_pin, en_pin, step_pin;
  logic [STEP_W-1:0]   o_freq_step;
  logic [LEVEL_W-1:0]  o_cal_level;
  logic                o_freq_id_select, o_cal_active, o_antenna_connected;
  logic                o_cal_preamp_sel, o_single_freq_mode, o_timing_lost;
  logic [STEP_W-1:0]   exp_step;
  int                  bad_count, checks;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and the parts under test.
  initial i_mclk = 1'b0;
  always #5 i_mclk = ~i_mclk;

  sc_timing_model partner (
    .i_mclk        (i_mclk),
    .o_frame_pin   (frame_pin),
    .o_disable_pin (dis_pin),
    .o_enable_pin  (en_pin),
    .o_step_pin    (step_pin)
  );

  step_cal_seq #(
    .CAL_FRAMES     (CAL_N),
    .FALLBACK_TICKS (FB_N)
  ) uut (
    .i_mclk                     (i_mclk),
    .i_rst_b                    (i_rst_b),
    .i_frame_timing_pulse       (frame_pin),
    .i_disable_stepping_command (dis_pin),
    .i_enable_stepping_command  (en_pin),
    .i_single_step_command      (step_pin),
    .o_freq_step                (o_freq_step),
    .o_freq_id_select           (o_freq_id_select),
    .o_cal_active               (o_cal_active),
    .o_antenna_connected        (o_antenna_connected),
    .o_cal_preamp_sel           (o_cal_preamp_sel),
    .o_cal_level                (o_cal_level),
    .o_single_freq_mode         (o_single_freq_mode),
    .o_timing_lost              (o_timing_lost)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Verdict; also reached when a bounded wait runs out.
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // Reset is held three cycles; outputs must show their idle values meanwhile.
  task automatic test_reset();
    i_rst_b = 1'b0;
    repeat (2) @(negedge i_mclk);
    `CHK(o_freq_step, 3'h0, "reset step")
    `CHK(o_antenna_connected, 1'b1, "reset antenna")
    `CHK(o_cal_active, 1'b0, "reset cal")
    `CHK(o_cal_level, 2'h0, "reset level")
    `CHK(o_freq_id_select, 1'b0, "reset id select")
    `CHK(o_cal_preamp_sel, 1'b0, "reset preamp")
    `CHK(o_single_freq_mode, 1'b0, "reset mode")
    `CHK(o_timing_lost, 1'b0, "reset lost")
    @(negedge i_mclk);
    i_rst_b = 1'b1;
    $display("test reset done");
  endtask : test_reset

  // First frame only aligns; each later frame advances one step and wraps after eight.
  task automatic test_stepping();
    partner.pulse(0);
    exp_step = 3'h0;
    `CHK(o_freq_step, exp_step, "align step")
    for (int i = 0; i < 17; i++) begin
      partner.pulse(0);
      exp_step = exp_step + 3'h1;
      `CHK(o_freq_step, exp_step, "step advance")
      `CHK(o_antenna_connected, 1'b1, "antenna outside cal")
      `CHK(o_cal_active, 1'b0, "no cal before interval")
    end
    $display("test stepping done");
  endtask : test_stepping

  // Waits for calibration, then follows it over all 128 frames.
  task automatic test_cal(input logic exp_preamp);
    int n;
    int ids;
    n = 0;
    ids = 0;
    while (o_cal_active !== 1'b1) begin
      `CHK(o_antenna_connected, 1'b1, "antenna idle")
      partner.pulse(0);
      n++;
      if (n > CAL_N + 20) begin
        `CHK(o_cal_active, 1'b1, "cal never started")
        summarize();
      end
    end
    `CHK(o_freq_step, 3'h0, "cal starts on first step")
    `CHK(o_cal_preamp_sel, exp_preamp, "preamp alternation")
    for (int i = 0; i < 128; i++) begin
      `CHK(o_cal_active, 1'b1, "cal length")
      `CHK(o_antenna_connected, 1'b0, "antenna off in cal")
      `CHK(o_cal_level, 2'((i / 8) % 4), "cal level")
      `CHK(o_cal_preamp_sel, exp_preamp, "preamp held")
      if (o_freq_id_select === 1'b1) ids++;
      partner.pulse(0);
    end
    `CHK(o_cal_active, 1'b0, "cal end")
    `CHK(o_antenna_connected, 1'b1, "antenna back")
    `CHK(ids, 8, "id frames per page")
    $display("test cal done");
  endtask : test_cal

  // Single frequency mode: frames are refused, single steps advance by one.
  task automatic test_single();
    partner.pulse(1);
    `CHK(o_single_freq_mode, 1'b1, "enter single")
    // The last calibration ended on a subcycle boundary, so the first step is active.
    exp_step = 3'h0;
    `CHK(o_freq_step, exp_step, "single entry step")
    repeat (3) partner.pulse(0);
    `CHK(o_freq_step, exp_step, "frames refused")
    for (int k = 0; k < 9; k++) begin
      partner.pulse(3);
      exp_step = exp_step + 3'h1;
      `CHK(o_freq_step, exp_step, "single step")
    end
    partner.pulse(2);
    `CHK(o_single_freq_mode, 1'b0, "leave single")
    partner.pulse(0);
    exp_step = exp_step + 3'h1;
    `CHK(o_freq_step, exp_step, "stepping resumes")
    `CHK(o_timing_lost, 1'b0, "no fallback")
    $display("test single done");
  endtask : test_single

  // Frame pulse withheld past the fallback timeout: one substitute step, then recovery.
  task automatic test_fallback();
    repeat (320) @(negedge i_mclk);
    exp_step = exp_step + 3'h1;
    `CHK(o_timing_lost, 1'b1, "fallback flagged")
    `CHK(o_freq_step, exp_step, "fallback step")
    partner.pulse(0);
    exp_step = exp_step + 3'h1;
    `CHK(o_timing_lost, 1'b0, "real pulse clears lost")
    `CHK(o_freq_step, exp_step, "real pulse steps")
    $display("test fallback done");
  endtask : test_fallback

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; single mode follows both cal tests so it cannot disturb the cal checks.
  initial begin
    bad_count = 0;
    checks = 0;
    test_reset();
    test_stepping();
    test_cal(1'b1);
    test_cal(1'b0);
    test_single();
    test_fallback();
    summarize();
  end
endmodule : test_step_cal_seq
